/* File: design/fir_pair_params.svh */
`ifndef FIR_PAIR_PARAMS_SVH
`define FIR_PAIR_PARAMS_SVH
// Register byte offsets; R_HCOEF is the PADDR[7:5] value of the helper coefficient page
`define R_HCTRL 8'h00
`define R_DCTRL 8'h04
`define R_DTAPS 8'h08
`define R_DOFF 8'h0C
`define R_START 8'h10
`define R_STOP 8'h14
`define R_CMEM 8'h18
`define R_STAT 8'h1C
`define R_HCOEF 3'h1
// Helper control fields
`define HC_TAPS 2:0
`define HC_SYM 3
`define HC_HALF 4
`define HC_BYP 5
`define HC_SCALE 7:6
`define HC_SRC 10:8
// Decimating control fields
`define DC_RATE 3:0
`define DC_PHASE 7:4
`define DC_SYM 8
`define DC_BYP 9
`define DC_SCALE 11:10
// Reset values
`define HCTRL_RST 11'h000
`define DCTRL_RST 12'h000
// Fraction bits of the coefficient formats
`define HFRAC 4'h5
`define DFRAC 5'h0D
// History depth: longest filter plus late samples
`define HIST 144
`endif

/* File: design/fir_pair_pkg.sv */
package fir_pair_pkg;
   // Sequencer states shared by both filter stages
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CALC = 2'b01,
      ST_DONE = 2'b10
   } calc_state_type;

   typedef logic signed [19:0] sample_type;

   // Clip a wide result into the 20-bit sample range
   function automatic sample_type sat20_f(input logic signed [41:0] v);
      if (v > 42'sh0007FFFF) begin
         return 20'h7FFFF;
      end else if (v < 42'sh3FFFFF80000) begin
         return 20'h80000;
      end
      return v[19:0];
   endfunction : sat20_f
endpackage : fir_pair_pkg

/* File: design/coef_ram.sv */
`timescale 1ns/1ps
// 64 x 14 coefficient store in flip-flops, one write and two read ports
module coef_ram (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [13:0] wdata,
   input wire logic [5:0] raddr_a,
   output logic [13:0] rdata_a,
   input wire logic [5:0] raddr_b,
   output logic [13:0] rdata_b
);
   logic [13:0] mem_q [0:63]; // One word per tap position

   // Each entry loads only when its own address is written
   for (genvar e = 0; e < 64; e++) begin : g_word
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            mem_q[e] <= 14'h0000;
         end else if (we && waddr == 6'(e)) begin
            mem_q[e] <= wdata;
         end
      end
   end

   // Filter and software reads never collide, so two plain ports
   assign rdata_a = mem_q[raddr_a];
   assign rdata_b = mem_q[raddr_b];
endmodule : coef_ram

/* File: design/helper_fir.sv */
`timescale 1ns/1ps
`include "fir_pair_params.svh"
// Non-decimating helper filter, one tap per step for I and Q
module helper_fir (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [2:0] taps_m1,
   input wire logic sym,
   input wire logic half,
   input wire logic bypass,
   input wire logic [1:0] scale,
   input wire logic [47:0] coef,
   input wire logic in_valid,
   input wire logic signed [19:0] in_i,
   input wire logic signed [19:0] in_q,
   output logic out_valid,
   output logic signed [19:0] out_i,
   output logic signed [19:0] out_q
);
   fir_pair_pkg::calc_state_type st_q;
   logic signed [19:0] dli_q [0:7]; // Delay line, newest first
   logic signed [19:0] dlq_q [0:7];
   logic [2:0] k_q; // Tap being summed
   logic tog_q; // Half-rate step divider
   logic signed [41:0] acci_q, accq_q;
   logic [2:0] mir, cidx;
   logic step;
   logic signed [5:0] c;
   logic [3:0] sh;

   // Mirror the stored half response when symmetric
   assign mir = taps_m1 - k_q;
   assign cidx = (sym && k_q > mir) ? mir : k_q;
   assign c = coef[6 * cidx +: 6]; // Eight per-tap coefficients, shared by I and Q
   // Half-clock mode advances only every second edge
   assign step = !half || tog_q;
   assign sh = `HFRAC + {2'b00, ~scale}; // Scale 11 means 0 dB

   // Delay line takes every incoming sample, rate in = rate out
   for (genvar e = 0; e < 8; e++) begin : g_dl
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            dli_q[e] <= 20'h00000;
            dlq_q[e] <= 20'h00000;
         end else if (in_valid) begin
            dli_q[e] <= (e == 0) ? in_i : dli_q[(e == 0) ? 0 : e - 1];
            dlq_q[e] <= (e == 0) ? in_q : dlq_q[(e == 0) ? 0 : e - 1];
         end
      end
   end

   // Sum of products over tap_count taps
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= fir_pair_pkg::ST_IDLE;
         k_q <= 3'h0;
         tog_q <= 1'b0;
         acci_q <= '0;
         accq_q <= '0;
         out_valid <= 1'b0;
         out_i <= 20'h00000;
         out_q <= 20'h00000;
      end else begin
         out_valid <= 1'b0;
         tog_q <= !tog_q;
         case (st_q)
            fir_pair_pkg::ST_IDLE: begin
               if (in_valid && bypass) begin
                  // Bypass passes the sample untouched
                  out_valid <= 1'b1;
                  out_i <= in_i;
                  out_q <= in_q;
               end else if (in_valid) begin
                  st_q <= fir_pair_pkg::ST_CALC;
                  k_q <= 3'h0;
                  tog_q <= 1'b0;
                  acci_q <= '0;
                  accq_q <= '0;
               end
            end
            fir_pair_pkg::ST_CALC: begin
               if (step) begin
                  acci_q <= acci_q + 42'(dli_q[k_q]) * 42'(c);
                  accq_q <= accq_q + 42'(dlq_q[k_q]) * 42'(c);
                  k_q <= k_q + 3'h1;
                  if (k_q == taps_m1) begin
                     st_q <= fir_pair_pkg::ST_DONE;
                  end
               end
            end
            fir_pair_pkg::ST_DONE: begin
               out_valid <= 1'b1;
               out_i <= fir_pair_pkg::sat20_f(acci_q >>> sh);
               out_q <= fir_pair_pkg::sat20_f(accq_q >>> sh);
               st_q <= fir_pair_pkg::ST_IDLE;
            end
            default: st_q <= fir_pair_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : helper_fir

/* File: design/fir_pair.sv */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fir_pair_params.svh"
// Summary of operation
// - Helper FIR, up to eight 6-bit taps
// - Helper tap count field holds taps minus one
// - Eight helper coefficients, 20-bit samples, same rate
// - Helper symmetry mirrors half the response
// - Half-clock bit halves helper compute rate
// - Helper bypass passes input unchanged
// - Helper 2-bit scale, 11 is 0 dB
// - Decimator: 64 asymmetric, 128 symmetric taps
// - Decimation 1 to 16, field holds rate-1
// - Decimator 20-bit data, 14-bit coefficients
// - Decimator taps register holds taps minus one
// - Decimator bypass: no scaling, input forwarded
// - Decimator own 2-bit scale, same encoding
// - Decimator symmetry uses half the response
// - New offset applies from next output sample
// - 4-bit decimation phase picks polyphase slot
// - One multiplier per path, one tap per clock
// - Each memory access advances RAM address
// - Equal start and stop addresses one word
// - 3-bit source field picks front end
module fir_pair (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [7:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [119:0] IN_I,
   input wire logic [119:0] IN_Q,
   input wire logic [5:0] IN_VALID,
   output logic [19:0] OUT_I,
   output logic [19:0] OUT_Q,
   output logic OUT_VALID
);
   // Software-visible state
   logic [10:0] hctrl_q; // Helper control
   logic [11:0] dctrl_q; // Decimator control
   logic [6:0] dtaps_q; // Decimator taps minus one
   logic [5:0] doff_q; // Coefficient offset
   logic [5:0] start_q, stop_q; // Load window
   logic [5:0] addr_q; // Auto-incrementing RAM pointer
   logic [47:0] hcoef_q; // Eight 6-bit helper coefficients
   logic pready_q, slverr_q;
   logic [31:0] prdata_q;

   // Bus decode
   wire setup = PSEL && !PENABLE;
   wire done_acc = PSEL && PENABLE && pready_q;
   wire wr = done_acc && PWRITE;
   wire hit_hctrl = PADDR == `R_HCTRL;
   wire hit_dctrl = PADDR == `R_DCTRL;
   wire hit_dtaps = PADDR == `R_DTAPS;
   wire hit_doff = PADDR == `R_DOFF;
   wire hit_start = PADDR == `R_START;
   wire hit_stop = PADDR == `R_STOP;
   wire hit_cmem = PADDR == `R_CMEM;
   wire hit_stat = PADDR == `R_STAT;
   wire hit_hcoef = PADDR[7:5] == `R_HCOEF && PADDR[1:0] == 2'b00;
   wire [2:0] hsel = PADDR[4:2]; // Helper coefficient index
   wire mapped = hit_hctrl || hit_dctrl || hit_dtaps || hit_doff ||
      hit_start || hit_stop || hit_cmem || hit_stat || hit_hcoef;

   // Decimator sequencer state
   fir_pair_pkg::calc_state_type st_q;
   logic [3:0] dcnt_q; // Position inside the decimation cycle
   logic [6:0] t_q; // Tap being summed
   logic [4:0] late_q; // Samples arrived since this output began
   logic [5:0] offl_q; // Offset frozen for the running output
   logic [7:0] nl_q; // Tap count frozen for the running output
   logic syml_q;
   logic signed [41:0] acci_q, accq_q;
   logic signed [19:0] hi_q [0:`HIST-1]; // Input history, newest first
   logic signed [19:0] hq_q [0:`HIST-1];

   // Wires between the stages
   logic [13:0] cram, cmem_rd;
   logic h_valid;
   logic signed [19:0] h_i, h_q;
   logic [31:0] rd_mux;

   // Front-end choice: 1x0 is channel 4, 1x1 channel 5
   wire [2:0] src = hctrl_q[`HC_SRC];
   wire [2:0] chan = src[2] ? {2'b10, src[0]} : {1'b0, src[1:0]};
   wire sel_valid = IN_VALID[chan];
   wire signed [19:0] sel_i = IN_I[20 * chan +: 20];
   wire signed [19:0] sel_q = IN_Q[20 * chan +: 20];

   // Decimator controls
   wire [3:0] rate_m1 = dctrl_q[`DC_RATE];
   wire [3:0] phase = dctrl_q[`DC_PHASE];
   wire dbyp = dctrl_q[`DC_BYP];
   wire [1:0] dscale = dctrl_q[`DC_SCALE];
   // Output slot chosen by the phase word
   wire fire = h_valid && !dbyp && dcnt_q == phase;
   wire [7:0] n_taps = {1'b0, dtaps_q} + 8'h01;

   // Symmetric half: tap t folds onto stored word j
   wire [7:0] m_half = (nl_q + 8'h01) >> 1;
   wire [7:0] t8 = {1'b0, t_q};
   wire [7:0] lo_part = nl_q - m_half;
   wire [7:0] j_sym = (t8 >= lo_part) ? t8 - lo_part
      : m_half - 8'h01 - t8;
   // Asymmetric words are stored last tap first
   wire [7:0] j_asym = nl_q - 8'h01 - t8;
   wire [7:0] j_sel = syml_q ? j_sym : j_asym;
   wire [5:0] caddr = offl_q + j_sel[5:0]; // Offset plus index
   wire signed [13:0] c = cram; // 14-bit coefficient
   wire [7:0] hidx = t8 + {3'b000, late_q};
   wire last_tap = t8 == nl_q - 8'h01;
   wire [4:0] sh = `DFRAC + {3'b000, ~dscale};

   // Pointer step wraps at stop back to start
   wire [5:0] addr_nxt = (addr_q == stop_q) ? start_q : addr_q + 6'h01;
   wire cmem_acc = done_acc && hit_cmem;
   wire cmem_we = cmem_acc && PWRITE;

   // Read mux, unmapped reads return zero
   assign rd_mux =
      hit_hctrl ? {21'h000000, hctrl_q} :
      hit_dctrl ? {20'h00000, dctrl_q} :
      hit_dtaps ? {25'h0000000, dtaps_q} :
      hit_doff ? {26'h0000000, doff_q} :
      hit_start ? {26'h0000000, start_q} :
      hit_stop ? {26'h0000000, stop_q} :
      hit_cmem ? {18'h00000, cmem_rd} :
      hit_stat ? {23'h000000, st_q != fir_pair_pkg::ST_IDLE, 2'b00,
                  addr_q} :
      hit_hcoef ? {26'h0000000, hcoef_q[6 * hsel +: 6]} :
      32'h00000000;

   // One coefficient store serves both multipliers
   coef_ram u_ram (
      .clk(CLOCK),
      .rst_n(RSTN),
      .we(cmem_we),
      .waddr(addr_q),
      .wdata(PWDATA[13:0]),
      .raddr_a(caddr),
      .rdata_a(cram),
      .raddr_b(addr_q),
      .rdata_b(cmem_rd)
   );

   // Helper stage between the router and the decimator
   helper_fir u_helper (
      .clk(CLOCK),
      .rst_n(RSTN),
      .taps_m1(hctrl_q[`HC_TAPS]),
      .sym(hctrl_q[`HC_SYM]),
      .half(hctrl_q[`HC_HALF]),
      .bypass(hctrl_q[`HC_BYP]),
      .scale(hctrl_q[`HC_SCALE]),
      .coef(hcoef_q),
      .in_valid(sel_valid),
      .in_i(sel_i),
      .in_q(sel_q),
      .out_valid(h_valid),
      .out_i(h_i),
      .out_q(h_q)
   );

   // Slave answers in the first access cycle, errors when unmapped
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= setup;
         slverr_q <= setup && !mapped;
         if (setup) begin
            prdata_q <= rd_mux; // Memory word read before the step
         end
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = slverr_q;
   assign PRDATA = prdata_q;

   // Control registers take writes at the completing edge
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         hctrl_q <= `HCTRL_RST;
         dctrl_q <= `DCTRL_RST;
         dtaps_q <= 7'h00;
         doff_q <= 6'h00;
         stop_q <= 6'h00;
      end else if (wr) begin
         if (hit_hctrl) hctrl_q <= PWDATA[10:0];
         if (hit_dctrl) dctrl_q <= PWDATA[11:0];
         if (hit_dtaps) dtaps_q <= PWDATA[6:0];
         if (hit_doff) doff_q <= PWDATA[5:0];
         if (hit_stop) stop_q <= PWDATA[5:0];
      end
   end

   // Writing start also reloads the pointer; any memory access steps it
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         start_q <= 6'h00;
         addr_q <= 6'h00;
      end else if (wr && hit_start) begin
         start_q <= PWDATA[5:0];
         addr_q <= PWDATA[5:0];
      end else if (cmem_acc) begin
         addr_q <= addr_nxt; // Reads step too
      end
   end

   // Helper coefficient registers, one per entry
   for (genvar e = 0; e < 8; e++) begin : g_hcoef
      always_ff @(posedge CLOCK) begin
         if (!RSTN) begin
            hcoef_q[6 * e +: 6] <= 6'h00;
         end else if (wr && hit_hcoef && hsel == 3'(e)) begin
            hcoef_q[6 * e +: 6] <= PWDATA[5:0];
         end
      end
   end

   // History shifts on every helper output
   for (genvar e = 0; e < `HIST; e++) begin : g_hist
      always_ff @(posedge CLOCK) begin
         if (!RSTN) begin
            hi_q[e] <= 20'h00000;
            hq_q[e] <= 20'h00000;
         end else if (h_valid) begin
            hi_q[e] <= (e == 0) ? h_i : hi_q[(e == 0) ? 0 : e - 1];
            hq_q[e] <= (e == 0) ? h_q : hq_q[(e == 0) ? 0 : e - 1];
         end
      end
   end

   // Decimation counter runs 0..rate-1 on each input
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         dcnt_q <= 4'h0;
      end else if (h_valid) begin
         dcnt_q <= (dcnt_q == rate_m1) ? 4'h0 : dcnt_q + 4'h1;
      end
   end

   // Late count keeps the taps aligned while history moves on
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         late_q <= 5'h00;
      end else if (fire && st_q == fir_pair_pkg::ST_IDLE) begin
         late_q <= 5'h00;
      end else if (h_valid && st_q == fir_pair_pkg::ST_CALC) begin
         late_q <= late_q + 5'h01;
      end
   end

   // Output sequencer: one tap per clock on each path
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         st_q <= fir_pair_pkg::ST_IDLE;
         t_q <= 7'h00;
         offl_q <= 6'h00;
         nl_q <= 8'h01;
         syml_q <= 1'b0;
         acci_q <= '0;
         accq_q <= '0;
         OUT_VALID <= 1'b0;
         OUT_I <= 20'h00000;
         OUT_Q <= 20'h00000;
      end else begin
         OUT_VALID <= 1'b0;
         case (st_q)
            fir_pair_pkg::ST_IDLE: begin
               if (h_valid && dbyp) begin
                  // Bypass forwards input with no scaling
                  OUT_VALID <= 1'b1;
                  OUT_I <= h_i;
                  OUT_Q <= h_q;
               end else if (fire) begin
                  // Offset and shape frozen per output
                  st_q <= fir_pair_pkg::ST_CALC;
                  offl_q <= doff_q;
                  nl_q <= n_taps;
                  syml_q <= dctrl_q[`DC_SYM];
                  t_q <= 7'h00;
                  acci_q <= '0;
                  accq_q <= '0;
               end
            end
            fir_pair_pkg::ST_CALC: begin
               // Single multiply per path this cycle
               acci_q <= acci_q + 42'(hi_q[hidx]) * 42'(c);
               accq_q <= accq_q + 42'(hq_q[hidx]) * 42'(c);
               t_q <= t_q + 7'h01;
               if (last_tap) begin
                  st_q <= fir_pair_pkg::ST_DONE;
               end
            end
            fir_pair_pkg::ST_DONE: begin
               OUT_VALID <= 1'b1;
               OUT_I <= fir_pair_pkg::sat20_f(acci_q >>> sh);
               OUT_Q <= fir_pair_pkg::sat20_f(accq_q >>> sh);
               st_q <= fir_pair_pkg::ST_IDLE;
            end
            default: st_q <= fir_pair_pkg::ST_IDLE;
         endcase
      end
   end
endmodule : fir_pair

/* File: testbench/fir_pair_asserts.sv */
`timescale 1ns/1ps
// Pin-level checks: APB answer timing and the pass-through path
module fir_pair_asserts (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic [7:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [119:0] IN_I,
   input wire logic [119:0] IN_Q,
   input wire logic [5:0] IN_VALID,
   input wire logic [19:0] OUT_I,
   input wire logic [19:0] OUT_Q,
   input wire logic OUT_VALID
);
   logic [11:0] hctl_q; // Shadow of the helper control word
   logic [11:0] dctl_q; // Shadow of the decimator control word
   logic setup; // APB setup cycle
   logic wr_done; // A write completes at this edge
   logic byp_both; // Both stages passed through
   logic [2:0] sel_ch; // Front end picked by the source field
   logic [19:0] sel_i; // Sample of the picked front end
   logic [19:0] sel_q;
   assign setup = PSEL && !PENABLE;
   assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
   assign byp_both = hctl_q[5] && dctl_q[9];
   // Middle bit of the source field is a don't-care above channel 3
   assign sel_ch = hctl_q[10] ? {2'b10, hctl_q[8]} : {1'b0, hctl_q[9:8]};
   assign sel_i = IN_I[sel_ch*20 +: 20];
   assign sel_q = IN_Q[sel_ch*20 +: 20];
   // Shadow copies follow completed writes only
   always_ff @(posedge CLOCK) begin
      if (!RSTN) begin
         hctl_q <= 12'h000;
         dctl_q <= 12'h000;
      end else if (wr_done && PADDR == 8'h00) begin
         hctl_q <= PWDATA[11:0];
      end else if (wr_done && PADDR == 8'h04) begin
         dctl_q <= PWDATA[11:0];
      end
   end
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   a_ready_answer: assert property (setup |=> PREADY)
      else $error("PREADY missing after setup");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("PREADY longer than one cycle");
   a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("PREADY outside an access");
   a_err_unmapped: assert property (setup && PADDR >= 8'h40 |=> PSLVERR)
      else $error("unmapped address not refused");
   a_err_mapped: assert property (setup && PADDR < 8'h40 |=> !PSLVERR)
      else $error("mapped address refused");
   a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("refused read not zero");
   a_read_upper: assert property (PREADY |-> PRDATA[31:14] == 18'h0)
      else $error("read data upper bits set");
   a_out_hold: assert property (!OUT_VALID |->
      $stable(OUT_I) && $stable(OUT_Q))
      else $error("output changed without valid");
   a_reset_quiet: assert property ($rose(RSTN) |-> !OUT_VALID && !PREADY)
      else $error("outputs active after reset");
   a_bypass_pass: assert property (
      byp_both && IN_VALID[sel_ch] |-> ##2 OUT_VALID
      && OUT_I == $past(sel_i, 2) && OUT_Q == $past(sel_q, 2))
      else $error("bypass path altered the sample");
endmodule : fir_pair_asserts

bind fir_pair fir_pair_asserts u_asserts (.CLOCK(CLOCK), .RSTN(RSTN),
   .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .IN_I(IN_I), .IN_Q(IN_Q), .IN_VALID(IN_VALID), .OUT_I(OUT_I),
   .OUT_Q(OUT_Q), .OUT_VALID(OUT_VALID));

/* File: testbench/fir_stream_model.sv */
`timescale 1ns/1ps
// Stand-in for the upstream router and the downstream filter
module fir_stream_model (
   input wire logic clk,
   output logic [119:0] dat_i,
   output logic [119:0] dat_q,
   output logic [5:0] dat_vld,
   input wire logic [19:0] res_i,
   input wire logic [19:0] res_q,
   input wire logic res_vld
);
   int cyc = 0; // Free-running cycle count
   int req_n = 0; // Samples asked for
   int done_n = 0; // Samples sent
   int t_in = 0; // Cycle a sample was taken
   int t_out = 0; // Cycle a result arrived
   int n_out = 0; // Results seen
   logic [2:0] req_ch = 3'h0;
   logic [19:0] req_i = 20'h00000;
   logic [19:0] req_q = 20'h00000;
   logic [19:0] last_i = 20'h00000; // Latest result
   logic [19:0] last_q = 20'h00000;
   initial begin
      dat_i = '0;
      dat_q = '0;
      dat_vld = 6'h00;
   end
   // Queue one sample; it leaves at the next edge
   task send(input logic [2:0] ch, input logic [19:0] si, sq);
      req_ch <= ch;
      req_i <= si;
      req_q <= sq;
      req_n <= req_n + 1;
   endtask : send
   // Lanes flip every idle cycle so stale data never looks valid
   always @(posedge clk) begin
      cyc <= cyc + 1;
      dat_i <= ~dat_i;
      dat_q <= ~dat_q;
      dat_vld <= 6'h00;
      if (req_n != done_n) begin
         done_n <= done_n + 1;
         dat_i[req_ch*20 +: 20] <= req_i;
         dat_q[req_ch*20 +: 20] <= req_q;
         dat_vld[req_ch] <= 1'b1;
      end
      if (|dat_vld) begin
         t_in <= cyc;
      end
      if (res_vld === 1'b1) begin
         t_out <= cyc;
         n_out <= n_out + 1;
         last_i <= res_i;
         last_q <= res_q;
      end
   end
endmodule : fir_stream_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// Register-driven tests of the filter pair
module tb_top;
   logic CLOCK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [119:0] IN_I, IN_Q;
   logic [5:0] IN_VALID;
   logic [19:0] OUT_I, OUT_Q;
   logic OUT_VALID;
   int n_fail = 0; // Mismatches
   int n_tests = 0; // Comparisons
   int cyc = 0; // Watchdog count
   logic [31:0] rd; // Last read data
   logic err; // Last refusal flag
   int lat_f, lat_h; // Latencies of two runs compared
   int n0, e, ch; // Result count before a step, expected value, channel
   int hc[8] = '{-7, 5, 11, 3, -2, 9, -14, 1}; // Helper taps
   int dh[8] = '{300, -200, 100, 0, 0, 0, 0, 0}; // Decimator taps
   int ds[8] = '{300, -200, 300, 0, 0, 0, 0, 0}; // Symmetric taps
   fir_pair uut (.CLOCK(CLOCK), .RSTN(RSTN), .PADDR(PADDR), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IN_I(IN_I),
      .IN_Q(IN_Q), .IN_VALID(IN_VALID), .OUT_I(OUT_I), .OUT_Q(OUT_Q),
      .OUT_VALID(OUT_VALID));
   fir_stream_model src (.clk(CLOCK), .dat_i(IN_I), .dat_q(IN_Q),
      .dat_vld(IN_VALID), .res_i(OUT_I), .res_q(OUT_Q),
      .res_vld(OUT_VALID));
   initial forever #4 CLOCK = ~CLOCK;
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] ac);
      n_tests++;
      if (ac !== ex) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, ac);
      end
   endtask : chk
   // One APB transfer; data and refusal are taken at the ready edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, rd);
   endtask : rdc
   // One sample; spacing is wide enough for the longest helper run
   task smp(input int c, input int vi, input int vq);
      src.send(c[2:0], vi[19:0], vq[19:0]);
      repeat (40) @(posedge CLOCK);
   endtask : smp
   // Flush with zeros, then an impulse; results appear tap by tap
   task frun(input logic [7:0] a, input logic [31:0] ctl, input int n,
      input bit mir, input int fr, input int co[8], output int lat);
      int j;
      wr(a, ctl);
      for (int k = 0; k < n + 8; k++) begin
         smp(0, k == 8 ? 1024 : 0, k == 8 ? 1024 : 0);
         if (k >= 8) begin
            j = k - 8;
            j = (mir && j > n - 1 - j) ? n - 1 - j : j;
            e = (co[j] * 1024) >>> fr;
            chk("tap i", e[19:0], src.last_i);
            chk("tap q", e[19:0], src.last_q);
         end
         if (k == 8) begin
            lat = src.t_out - src.t_in;
         end
      end
   endtask : frun
   task finish_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // Watchdog; the run needs some 6000 cycles
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      repeat (10) @(posedge CLOCK);
      RSTN <= 1'b1;
      rdc("helper ctrl", 8'h00, 32'h0);
      rdc("decim ctrl", 8'h04, 32'h0);
      rdc("status", 8'h1C, 32'h0);
      wr(8'h40, 32'hFFFF);
      chk("write refused", 32'h1, {31'h0, err});
      rdc("unmapped", 8'h40, 32'h0);
      // Every source code, both stages bypassed, scaling words at 00
      wr(8'h04, 32'h200);
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 32'h20 | (s << 8));
         ch = s < 4 ? s : 4 + s % 2;
         n0 = src.n_out;
         smp(ch == 5 ? 0 : ch + 1, 20'h0BAD0, 20'h0BAD0);
         smp(ch, 20'h12340 + s, 20'h54320 + s);
         chk("one result", n0 + 1, src.n_out);
         chk("pass i", 20'h12340 + s, src.last_i);
         chk("pass q", 20'h54320 + s, src.last_q);
         chk("pass time", 32'h2, src.t_out - src.t_in);
      end
      // Helper taps, one signed read-back, then each scaling word
      for (int i = 0; i < 8; i++) wr(8'(8'h20 + 4 * i), hc[i] & 32'h3F);
      rdc("helper coef", 8'h20, 32'h39);
      for (int s = 0; s < 4; s++) begin
         wr(8'h00, s << 6);
         smp(0, 1024, 1024);
         e = (hc[0] * 1024) >>> (8 - s);
         chk("helper scale", e[19:0], src.last_i);
      end
      frun(8'h00, 32'hC2, 3, 0, 5, hc, lat_f);
      frun(8'h00, 32'hD2, 3, 0, 5, hc, lat_h);
      chk("half rate", 32'h3, lat_h - lat_f);
      frun(8'h00, 32'hC7, 8, 0, 5, hc, lat_f);
      frun(8'h00, 32'hCC, 5, 1, 5, hc, lat_f);
      frun(8'h00, 32'hCD, 6, 1, 5, hc, lat_f);
      // Decimator taps written last first, read back after the wrap
      wr(8'h00, 32'h20);
      wr(8'h08, 32'h2);
      wr(8'h0C, 32'hA);
      wr(8'h10, 32'hA);
      wr(8'h14, 32'hC);
      for (int i = 2; i >= 0; i--) wr(8'h18, dh[i] & 32'h3FFF);
      rdc("pointer", 8'h1C, 32'hA);
      for (int i = 2; i >= 0; i--)
         rdc("coef", 8'h18, dh[i] & 32'h3FFF);
      frun(8'h04, 32'hC00, 3, 0, 13, dh, lat_f);
      // Second filter at another offset, stored from the middle out
      wr(8'h0C, 32'h14);
      wr(8'h10, 32'h14);
      wr(8'h14, 32'h15);
      wr(8'h18, dh[1] & 32'h3FFF);
      wr(8'h18, 32'h12C);
      frun(8'h04, 32'hD00, 3, 0, 13, ds, lat_h);
      // One tap from the first filter under each scaling word
      wr(8'h0C, 32'hA);
      wr(8'h08, 32'h0);
      for (int s = 0; s < 4; s++) begin
         wr(8'h04, s << 10);
         smp(0, 1024, 1024);
         e = (dh[2] * 1024) >>> (16 - s);
         chk("decim scale", e[19:0], src.last_i);
      end
      chk("tap per clock", 32'h2, lat_f - (src.t_out - src.t_in));
      // Offset moved as the output starts: the old word is still used
      src.send(3'h0, 20'h00400, 20'h00400);
      wr(8'h0C, 32'h14);
      repeat (40) @(posedge CLOCK);
      chk("old offset", e[19:0], src.last_i);
      // Rate two in each phase, a phase past the rate, then rate 16
      for (int p = 0; p < 4; p++) begin
         n0 = src.n_out;
         wr(8'h04, p == 3 ? 32'hC0F : 32'hC01 | (p << 4));
         for (int k = 0; k < (p == 3 ? 16 : 4); k++) smp(0, 1024, 0);
         chk("outputs", (p != 2) + (p < 2), src.n_out - n0);
      end
      // Start equal to stop pins the pointer on one word
      wr(8'h10, 32'h21);
      wr(8'h14, 32'h21);
      wr(8'h18, 32'h1ABC);
      rdc("single", 8'h18, 32'h1ABC);
      rdc("single", 8'h18, 32'h1ABC);
      rdc("pointer", 8'h1C, 32'h21);
      finish_test;
   end
endmodule : tb_top
